// *** rtl/ulph_buf2.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "ulph_map.svh"

module ulph_buf2
#(
  parameter int W = `ULPH_WORD_W
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [W-1:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_rready
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [W-1:0] d0_reg;
  logic [W-1:0] d1_reg;
  logic wready_reg;

  wire push = i_wvalid & wready_reg;
  wire pop = o_rvalid & i_rready;
  wire load_d0 = (push & ~pop & (cnt_reg == `ULPH_BUF_EMPTY))
    | (push & pop & (cnt_reg == `ULPH_BUF_ONE));
  wire load_d1 = push & (((cnt_reg == `ULPH_BUF_ONE) & ~pop)
    | ((cnt_reg == `ULPH_BUF_FULL) & pop));
  wire shift = pop & (cnt_reg == `ULPH_BUF_FULL);

  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  assign o_rvalid = (cnt_reg != `ULPH_BUF_EMPTY);
  assign o_rdata = d0_reg;
  assign o_wready = wready_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_reg <= `ULPH_BUF_EMPTY;
      wready_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      wready_reg <= (cnt_next != `ULPH_BUF_FULL);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (load_d0)
      d0_reg <= i_wdata;
    else if (shift)
      d0_reg <= d1_reg;
    if (load_d1)
      d1_reg <= i_wdata;
  end

endmodule

// *** rtl/ulph_map.svh ***
// Constants of the ULPI pin handshake and reset block.
// Assumes inclusion by its bare name from every design file except the package.
// Overview of operation
// - While chip reset is low the device is suspended and regulators off.
// - Reset held low at least 1 us; release restores defaults everywhere.
// - Chip reset may change at any moment, unrelated to any clock.
// - With chip reset high the link interface works as a normal transceiver.
// - STP comes the cycle after the final byte; that byte is the last.
// - Device with data for the link drives DIR high and owns the bus.
// - Device without data holds DIR low and watches the bus for commands.
// - While chip reset is low all interface pins float.
// - In clock-output setup outputs launch on the interface clock's rising edge.
// - NXT throttles; on link-to-device transfers it marks the accepted byte.
`ifndef ULPH_MAP_SVH
`define ULPH_MAP_SVH

`define ULPH_DATA_W 8
`define ULPH_WORD_W 9
`define ULPH_LAST_BIT 8
`define ULPH_BUS_IDLE 8'h00
`define ULPH_MCLK_MHZ 25
`define ULPH_T_RST_MIN_NS 1000
`define ULPH_RST_MIN_CYC ((`ULPH_T_RST_MIN_NS * `ULPH_MCLK_MHZ + 999) / 1000)
`define ULPH_RST_CNT_W 5
`define ULPH_BUF_CNT_W 2
`define ULPH_BUF_EMPTY 2'h0
`define ULPH_BUF_ONE 2'h1
`define ULPH_BUF_FULL 2'h2

`endif

// *** rtl/ulph_pkg.sv ***
// Types of the ULPI pin handshake and reset block.
// Assumes nothing of its surroundings.
package ulph_pkg;

  typedef enum logic [1:0]
  {
    LS_IDLE = 2'b00,
    LS_RX = 2'b01,
    LS_TURN = 2'b10,
    LS_TX = 2'b11
  } ulph_link_state_t;

endpackage

// *** rtl/ulph_top.sv ***
// Link-side pin logic of a ULPI transceiver: reset, suspend, DIR/NXT/STP handshake.
// Assumes I_REF_CLOCK_IN is the interface clock and the core runs on I_MCLK.
`timescale 1ns/1ps
`include "ulph_map.svh"

module ulph_top
(
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_REF_CLOCK_IN,
  input wire logic I_CHIP_RESET_LOW,
  input wire logic I_STP,
  input wire logic [7:0] I_DATA,
  output logic [7:0] O_DATA,
  output logic O_DATA_OE,
  output logic O_DIR,
  output logic O_DIR_OE,
  output logic O_NXT,
  output logic O_NXT_OE,
  output logic O_REG_ENABLE,
  output logic O_SHORT_RESET,
  input wire logic [7:0] I_UP_DATA,
  input wire logic I_UP_LAST,
  input wire logic I_UP_VALID,
  output logic O_UP_READY,
  output logic [7:0] O_DN_DATA,
  output logic O_DN_LAST,
  output logic O_DN_VALID,
  input wire logic I_DN_READY
);

  // ****************************************
  // Core clock domain: reset and suspend
  // ****************************************
  logic cm1_reg, cm2_reg, cm3_reg;
  logic reg_en_reg, short_reg;
  logic [`ULPH_RST_CNT_W-1:0] low_cnt_reg;
  logic ua_tog_reg, dn_tog_reg, up_pend_reg;
  logic [`ULPH_WORD_W-1:0] send_word_reg;

  // Pin is asynchronous; two stages before use
  always_ff @(posedge I_MCLK)
  begin
    cm1_reg <= I_CHIP_RESET_LOW;
    cm2_reg <= cm1_reg;
    cm3_reg <= cm2_reg;
  end

  wire core_rst = I_SRST | ~cm2_reg;
  wire low_sat = (low_cnt_reg == `ULPH_RST_CNT_W'(`ULPH_RST_MIN_CYC));
  wire chip_rel = cm2_reg & ~cm3_reg;

  always_ff @(posedge I_MCLK)
  begin
    reg_en_reg <= cm2_reg & ~I_SRST;
    if (I_SRST)
      low_cnt_reg <= '0;
    else if (~cm2_reg & ~low_sat)
      low_cnt_reg <= low_cnt_reg + `ULPH_RST_CNT_W'(1);
    else if (cm2_reg)
      low_cnt_reg <= '0;
    if (I_SRST)
      short_reg <= 1'b0;
    else if (chip_rel)
      short_reg <= ~low_sat;
  end

  // ****************************************
  // Core domain: upstream buffer and sender
  // ****************************************
  logic [`ULPH_WORD_W-1:0] buf_word;
  logic buf_valid;
  logic [`ULPH_WORD_W-1:0] up_word_reg;
  logic up_req_reg, up_busy_reg;
  logic ua1_reg, ua2_reg, ua3_reg;

  wire up_ack_edge = ua2_reg ^ ua3_reg;
  wire up_take = buf_valid & ~up_busy_reg;

  ulph_buf2 #(.W(`ULPH_WORD_W)) u_buf
  (
    .i_clk(I_MCLK),
    .i_rst(core_rst),
    .i_wdata({I_UP_LAST, I_UP_DATA}),
    .i_wvalid(I_UP_VALID),
    .o_wready(O_UP_READY),
    .o_rdata(buf_word),
    .o_rvalid(buf_valid),
    .i_rready(~up_busy_reg)
  );

  always_ff @(posedge I_MCLK)
  begin
    ua1_reg <= ua_tog_reg;
    ua2_reg <= ua1_reg;
    ua3_reg <= ua2_reg;
    if (core_rst)
    begin
      up_req_reg <= 1'b0;
      up_busy_reg <= 1'b0;
    end
    else if (up_take)
    begin
      up_word_reg <= buf_word;
      up_req_reg <= ~up_req_reg;
      up_busy_reg <= 1'b1;
    end
    else if (up_ack_edge)
      up_busy_reg <= 1'b0;
  end

  // ****************************************
  // Core domain: downstream receiver
  // ****************************************
  logic dr1_reg, dr2_reg, dr3_reg;
  logic dn_ack_reg, dn_valid_reg, dn_last_reg;
  logic [7:0] dn_data_reg;

  wire dn_req_edge = dr2_reg ^ dr3_reg;
  wire dn_pop = dn_valid_reg & I_DN_READY;

  always_ff @(posedge I_MCLK)
  begin
    dr1_reg <= dn_tog_reg;
    dr2_reg <= dr1_reg;
    dr3_reg <= dr2_reg;
    if (core_rst)
    begin
      dn_valid_reg <= 1'b0;
      dn_ack_reg <= 1'b0;
      dn_data_reg <= `ULPH_BUS_IDLE;
      dn_last_reg <= 1'b0;
    end
    else if (dn_req_edge)
    begin
      dn_valid_reg <= 1'b1;
      dn_data_reg <= send_word_reg[7:0];
      dn_last_reg <= send_word_reg[`ULPH_LAST_BIT];
    end
    else if (dn_pop)
    begin
      dn_valid_reg <= 1'b0;
      dn_ack_reg <= ~dn_ack_reg;
    end
  end

  // ****************************************
  // Link clock domain
  // ****************************************
  logic cl1_reg, cl2_reg, sr1_reg, sr2_reg, link_rst_reg;
  logic ur1_reg, ur2_reg, ur3_reg, da1_reg, da2_reg, da3_reg;
  logic send_busy_reg, hold_v_reg, stp_pend_reg;
  logic [7:0] hold_reg;
  ulph_pkg::ulph_link_state_t state_reg, state_next;
  logic dir_reg, dir_next, nxt_reg, nxt_next, oe_reg, oe_next, pins_on_reg;
  logic [7:0] dout_reg, dout_next;

  always_ff @(posedge I_REF_CLOCK_IN)
  begin
    cl1_reg <= I_CHIP_RESET_LOW;
    cl2_reg <= cl1_reg;
    sr1_reg <= I_SRST;
    sr2_reg <= sr1_reg;
    link_rst_reg <= ~cl2_reg | sr2_reg;
    ur1_reg <= up_req_reg;
    ur2_reg <= ur1_reg;
    ur3_reg <= ur2_reg;
    da1_reg <= dn_ack_reg;
    da2_reg <= da1_reg;
    da3_reg <= da2_reg;
  end

  wire up_req_edge = ur2_reg ^ ur3_reg;
  wire dn_ack_edge = da2_reg ^ da3_reg;
  wire bus_cmd = ~dir_reg & ~oe_reg & (I_DATA != `ULPH_BUS_IDLE);
  wire rx_cap = (state_reg == ulph_pkg::LS_RX) & nxt_reg & ~I_STP;
  wire end_req = (state_reg == ulph_pkg::LS_RX) & (I_STP | stp_pend_reg);
  wire flush = end_req & hold_v_reg & ~send_busy_reg;
  wire push_send = flush | (rx_cap & hold_v_reg);
  wire tx_take = (state_reg == ulph_pkg::LS_TX) & up_pend_reg;
  wire tx_last = up_word_reg[`ULPH_LAST_BIT];

  // Bus ownership and throttling
  always_comb
  begin
    state_next = state_reg;
    dir_next = 1'b0;
    nxt_next = 1'b0;
    oe_next = 1'b0;
    dout_next = `ULPH_BUS_IDLE;
    case (state_reg)
      ulph_pkg::LS_IDLE:
      begin
        if (bus_cmd & ~send_busy_reg & ~hold_v_reg)
        begin
          state_next = ulph_pkg::LS_RX;
          nxt_next = 1'b1;
        end
        else if (up_pend_reg & ~bus_cmd)
        begin
          state_next = ulph_pkg::LS_TURN;
          dir_next = 1'b1;
        end
      end
      ulph_pkg::LS_RX:
      begin
        if (end_req & (~hold_v_reg | flush))
          state_next = ulph_pkg::LS_IDLE;
        else
          nxt_next = ~send_busy_reg & ~nxt_reg & ~end_req;
      end
      ulph_pkg::LS_TURN:
      begin
        state_next = ulph_pkg::LS_TX;
        dir_next = 1'b1;
        oe_next = 1'b1;
      end
      ulph_pkg::LS_TX:
      begin
        dir_next = 1'b1;
        oe_next = 1'b1;
        if (tx_take)
        begin
          nxt_next = 1'b1;
          dout_next = up_word_reg[7:0];
          if (tx_last)
            state_next = ulph_pkg::LS_IDLE;
        end
      end
      default:
        state_next = ulph_pkg::LS_IDLE;
    endcase
  end

  // All pins launched on the interface clock rising edge
  always_ff @(posedge I_REF_CLOCK_IN)
  begin
    if (link_rst_reg)
    begin
      state_reg <= ulph_pkg::LS_IDLE;
      dir_reg <= 1'b0;
      nxt_reg <= 1'b0;
      oe_reg <= 1'b0;
      pins_on_reg <= 1'b0;
      dout_reg <= `ULPH_BUS_IDLE;
    end
    else
    begin
      state_reg <= state_next;
      dir_reg <= dir_next;
      nxt_reg <= nxt_next;
      oe_reg <= oe_next;
      pins_on_reg <= 1'b1;
      dout_reg <= dout_next;
    end
  end

  // Handshake state of the link domain
  always_ff @(posedge I_REF_CLOCK_IN)
  begin
    if (link_rst_reg)
    begin
      ua_tog_reg <= 1'b0;
      dn_tog_reg <= 1'b0;
      up_pend_reg <= 1'b0;
      send_busy_reg <= 1'b0;
      hold_v_reg <= 1'b0;
      stp_pend_reg <= 1'b0;
    end
    else
    begin
      if (tx_take)
      begin
        up_pend_reg <= 1'b0;
        ua_tog_reg <= ~ua_tog_reg;
      end
      else if (up_req_edge)
        up_pend_reg <= 1'b1;
      if (push_send)
      begin
        send_word_reg <= {flush, hold_reg};
        dn_tog_reg <= ~dn_tog_reg;
        send_busy_reg <= 1'b1;
      end
      else if (dn_ack_edge)
        send_busy_reg <= 1'b0;
      if (rx_cap)
      begin
        hold_reg <= I_DATA;
        hold_v_reg <= 1'b1;
      end
      else if (flush)
        hold_v_reg <= 1'b0;
      stp_pend_reg <= end_req & ~flush & hold_v_reg;
    end
  end

  assign O_DATA = dout_reg;
  assign O_DATA_OE = oe_reg;
  assign O_DIR = dir_reg;
  assign O_DIR_OE = pins_on_reg;
  assign O_NXT = nxt_reg;
  assign O_NXT_OE = pins_on_reg;
  assign O_REG_ENABLE = reg_en_reg;
  assign O_SHORT_RESET = short_reg;
  assign O_DN_DATA = dn_data_reg;
  assign O_DN_LAST = dn_last_reg;
  assign O_DN_VALID = dn_valid_reg;

  // ****************************************
  // Assertions
  // ****************************************
  a_regs_off_low: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !cm2_reg |=> !reg_en_reg) else $error("regulators on during chip reset");
  a_short_flag: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    chip_rel && !low_sat |=> short_reg) else $error("short reset not flagged");
  a_dn_default: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    !cm2_reg |=> !dn_valid_reg && !up_busy_reg) else $error("core state not reset");
  a_pins_float: assert property (@(posedge I_REF_CLOCK_IN)
    !cl2_reg |-> ##2 (!O_DATA_OE && !O_DIR_OE && !O_NXT_OE))
    else $error("pins driven in reset");
  a_pins_driven: assert property (@(posedge I_REF_CLOCK_IN)
    !link_rst_reg |=> O_DIR_OE && O_NXT_OE) else $error("pins not driven in operation");
  a_data_owner: assert property (@(posedge I_REF_CLOCK_IN) disable iff (link_rst_reg)
    O_DATA_OE |-> O_DIR && $past(dir_reg)) else $error("data driven without turnaround");
  a_idle_listen: assert property (@(posedge I_REF_CLOCK_IN) disable iff (link_rst_reg)
    state_reg == ulph_pkg::LS_RX |-> !O_DIR && !O_DATA_OE) else $error("bus taken while receiving");
  a_nxt_accept: assert property (@(posedge I_REF_CLOCK_IN) disable iff (link_rst_reg)
    rx_cap |=> hold_v_reg && hold_reg == $past(I_DATA)) else $error("accepted byte not held");
  a_stp_last: assert property (@(posedge I_REF_CLOCK_IN) disable iff (link_rst_reg)
    flush |=> send_word_reg[`ULPH_LAST_BIT] && state_reg == ulph_pkg::LS_IDLE)
    else $error("last byte not marked");
  a_tx_done: assert property (@(posedge I_REF_CLOCK_IN) disable iff (link_rst_reg)
    tx_take && tx_last |=> O_NXT ##1 !O_DIR) else $error("DIR not released after last byte");

  c_up_packet: cover property (@(posedge I_REF_CLOCK_IN) tx_take && tx_last);
  c_dn_packet: cover property (@(posedge I_MCLK) dn_pop && dn_last_reg);
  c_rx_stall: cover property (@(posedge I_MCLK) (dn_valid_reg && !I_DN_READY) [*3]);
  c_up_full: cover property (@(posedge I_MCLK) I_UP_VALID && !O_UP_READY);

endmodule

// *** test/ulph_link_model.sv ***
// Link controller model facing the ULPI pins of the block.
// Assumes the bench supplies the interface clock and resolved DIR and NXT levels.
`timescale 1ns/1ps

module ulph_link_model
(
  input wire logic i_clk,
  input wire logic i_dir,
  input wire logic i_nxt,
  input wire logic i_dev_oe,
  input wire logic [7:0] i_dev_data,
  output logic [7:0] o_bus,
  output logic o_stp
);
  logic [7:0] drv = 8'h00;
  logic [7:0] last_bus = 8'h00;
  logic [7:0] up_q[$];
  int timeouts = 0;

  // Undriven bus toggles so stale data never looks valid
  assign o_bus = i_dev_oe ? i_dev_data : (i_dir ? ~last_bus : drv);

  initial o_stp = 1'b0;

  always @(posedge i_clk) last_bus <= o_bus;

  always @(posedge i_clk)
  begin
    if (i_dir === 1'b1 && i_nxt === 1'b1 && i_dev_oe === 1'b1)
    begin
      up_q.push_back(i_dev_data);
    end
  end

  task automatic send(input logic [7:0] b[$]);
    int i;
    int n;
    logic ok;
    n = 0;
    do
    begin
      @(negedge i_clk);
      ok = (i_dir === 1'b0);
      @(posedge i_clk);
      n++;
    end while (!ok && n < 200);
    for (i = 0; i < b.size(); i++)
    begin
      drv <= b[i];
      ok = 1'b0;
      while (!ok && n < 400)
      begin
        @(negedge i_clk);
        ok = (i_nxt === 1'b1);
        @(posedge i_clk);
        n++;
      end
    end
    if (n >= 400)
      timeouts++;
    drv <= 8'h00;
    o_stp <= 1'b1;
    @(posedge i_clk);
    o_stp <= 1'b0;
  endtask
endmodule

// *** test/ulph_top_test.sv ***
// Self-checking bench of the ULPI pin handshake and reset block.
// Assumes the link model is compiled before this file.
`timescale 1ns/1ps

module ulph_top_test;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic srst = 1'b1;
  logic chip_rst_n = 1'b1;
  logic [7:0] up_data = 8'h00;
  logic up_last = 1'b0;
  logic up_valid = 1'b0;
  logic dn_ready = 1'b1;
  logic [7:0] bus, dev_data, dn_data;
  logic stp, dev_oe, dir, dir_oe, nxt, nxt_oe, reg_en, short_rst;
  logic up_ready, dn_last, dn_valid;
  logic [8:0] dn_q[$];
  int err_count = 0;
  int comparisons = 0;
  int refusals = 0;

  initial forever #20 mclk = ~mclk;
  initial
  begin
    #7;
    forever #15 lclk = ~lclk;
  end

  ulph_top u_dut
  (
    .I_MCLK(mclk), .I_SRST(srst), .I_REF_CLOCK_IN(lclk), .I_CHIP_RESET_LOW(chip_rst_n),
    .I_STP(stp), .I_DATA(bus), .O_DATA(dev_data), .O_DATA_OE(dev_oe), .O_DIR(dir),
    .O_DIR_OE(dir_oe), .O_NXT(nxt), .O_NXT_OE(nxt_oe), .O_REG_ENABLE(reg_en),
    .O_SHORT_RESET(short_rst), .I_UP_DATA(up_data), .I_UP_LAST(up_last),
    .I_UP_VALID(up_valid), .O_UP_READY(up_ready), .O_DN_DATA(dn_data),
    .O_DN_LAST(dn_last), .O_DN_VALID(dn_valid), .I_DN_READY(dn_ready)
  );

  ulph_link_model u_link
  (
    .i_clk(lclk), .i_dir(dir & dir_oe), .i_nxt(nxt & nxt_oe), .i_dev_oe(dev_oe),
    .i_dev_data(dev_data), .o_bus(bus), .o_stp(stp)
  );

  always @(posedge mclk)
  begin
    if (dn_valid === 1'b1 && dn_ready === 1'b1)
      dn_q.push_back({dn_last, dn_data});
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic timeout(input string what);
    err_count++;
    $display("Error %s expected handshake seen timeout", what);
    end_of_test();
  endtask

  task automatic wait_q(input int want, input bit up);
    int n;
    n = 0;
    while ((up ? u_link.up_q.size() : dn_q.size()) < want && n < 600)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 600)
      timeout("queue");
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_idle;
    repeat (10) @(posedge lclk);
    @(negedge lclk);
    check("dir_oe", 9'(dir_oe), 9'h001);
    check("dir_idle", 9'(dir), 9'h000);
    check("reg_enable", 9'(reg_en), 9'h001);
    check("short_flag", 9'(short_rst), 9'h000);
  endtask

  task automatic t_rx(input logic [7:0] b[$], input int stall);
    int i;
    dn_q.delete();
    @(posedge mclk);
    dn_ready <= 1'b0;
    fork
      u_link.send(b);
      begin
        repeat (stall) @(posedge mclk);
        @(negedge mclk);
        check("stall_held", 9'(dn_q.size()), 9'h000);
        check("stall_valid", 9'(dn_valid), 9'h001);
        check("stall_word", {dn_last, dn_data}, {b.size() == 1, b[0]});
        @(posedge mclk);
        dn_ready <= 1'b1;
      end
    join
    wait_q(b.size(), 1'b0);
    check("rx_count", 9'(dn_q.size()), 9'(b.size()));
    for (i = 0; i < b.size(); i++)
      check("rx_word", dn_q[i], {i == b.size() - 1, b[i]});
  endtask

  task automatic t_tx;
    int i;
    int n;
    logic rdy;
    logic [8:0] w[5];
    w = '{9'h05a, 9'h0a5, 9'h001, 9'h0ff, 9'h180};
    u_link.up_q.delete();
    @(posedge mclk);
    for (i = 0; i < 5; i++)
    begin
      up_data <= w[i][7:0];
      up_last <= w[i][8];
      up_valid <= 1'b1;
      n = 0;
      do
      begin
        @(negedge mclk);
        rdy = up_ready;
        @(posedge mclk);
        n++;
        if (rdy !== 1'b1)
          refusals++;
      end while (rdy !== 1'b1 && n < 100);
      if (n >= 100)
        timeout("up_ready");
    end
    up_valid <= 1'b0;
    check("buffer_refused", 9'(refusals > 0), 9'h001);
    wait_q(5, 1'b1);
    for (i = 0; i < 5; i++)
      check("tx_byte", {1'b0, u_link.up_q[i]}, {1'b0, w[i][7:0]});
    repeat (4) @(posedge lclk);
    @(negedge lclk);
    check("dir_released", 9'(dir), 9'h000);
  endtask

  task automatic t_chip(input int len, input logic exp_short);
    @(posedge lclk);
    chip_rst_n <= 1'b0;
    repeat (len) @(posedge mclk);
    @(negedge lclk);
    check("reg_off", 9'(reg_en), 9'h000);
    check("pins_float", 9'({dev_oe, dir_oe, nxt_oe}), 9'h000);
    @(posedge lclk);
    chip_rst_n <= 1'b1;
    repeat (12) @(posedge mclk);
    @(negedge lclk);
    check("reg_on", 9'(reg_en), 9'h001);
    check("short_flag", 9'(short_rst), 9'(exp_short));
    check("pins_back", 9'({dev_oe, dir_oe, nxt_oe}), 9'h003);
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    t_idle();
    t_rx('{8'h41, 8'h11, 8'h22, 8'h33}, 40);
    t_tx();
    t_chip(30, 1'b0);
    t_chip(10, 1'b1);
    t_rx('{8'h5c}, 20);
    check("link_timeouts", 9'(u_link.timeouts), 9'h000);
    end_of_test();
  end
endmodule
